/* File: design/mcbx_consts.svh */
// Constants for the multiply, compare and branch execution block
`ifndef MCBX_CONSTS_SVH
`define MCBX_CONSTS_SVH
// Register byte addresses
`define MCBX_A_INSTR 8'h00
`define MCBX_A_PC 8'h04
`define MCBX_A_FLAGS 8'h08
`define MCBX_A_IO 8'h0C
`define MCBX_A_STAT 8'h10
`define MCBX_A_RET 8'h14
// Address bit that selects the general register window
`define MCBX_A_GPR_BIT 7
// Fields inside the instruction word
`define MCBX_F_BIT 2:0
`define MCBX_F_SEL 2:0
`define MCBX_F_LONG 8
// Status flag positions
`define MCBX_FLAG_C 0
`define MCBX_FLAG_Z 1
`define MCBX_FLAG_N 2
`define MCBX_FLAG_V 3
`define MCBX_FLAG_H 5
`define MCBX_FLAG_T 6
// Pointer register pair
`define MCBX_ZLO 5'h1E
`define MCBX_ZHI 5'h1F
// Reset values
`define MCBX_RST_PC 16'h0000
`define MCBX_RST_FLAGS 8'h00
// Execution times in clock cycles
`define MCBX_CYC_ONE 3'h1
`define MCBX_CYC_TWO 3'h2
`define MCBX_CYC_THREE 3'h3
`define MCBX_CYC_FOUR 3'h4
`endif

/* File: design/mcbx_pkg.sv */
// Types for the multiply, compare and branch execution block
`default_nettype none
package mcbx_pkg;
  typedef enum logic [5:0] {
    OP_NOP, OP_BIT_CLEAR, OP_PROBE,
    OP_PROD_U, OP_PROD_S, OP_PROD_SU, OP_FRAC_U, OP_FRAC_S, OP_FRAC_SU,
    OP_REL_JUMP, OP_REL_INVOKE, OP_IND_JUMP, OP_IND_INVOKE,
    OP_ABS_JUMP, OP_ABS_INVOKE,
    OP_CMP_SKIP, OP_COMPARE, OP_CMP_CARRY, OP_CMP_IMM,
    OP_SKIP_REG_CLR, OP_SKIP_REG_SET, OP_SKIP_IO_CLR, OP_SKIP_IO_SET,
    OP_BR_FLAG_SET, OP_BR_FLAG_CLR, OP_BR_C1, OP_BR_C0, OP_BR_UGE, OP_BR_ULT,
    OP_BR_SGE, OP_BR_SLT, OP_BR_H1, OP_BR_H0, OP_BR_T1, OP_BR_T0,
    OP_BR_V1, OP_BR_V0, OP_BR_EQ, OP_BR_NE, OP_BR_NEG, OP_BR_POS
  } mcbx_op_t;

  typedef enum logic [1:0] {
    MCBX_IDLE = 2'h1,
    MCBX_EXEC = 2'h2
  } mcbx_state_t;

  typedef struct packed {
    mcbx_op_t op;
    logic [4:0] d;
    logic [4:0] r;
    logic [15:0] imm;
  } mcbx_instr_t;

  typedef struct packed {
    mcbx_state_t st;
    logic [2:0] cnt;
    logic [2:0] last_cyc;
    logic wreq;
    logic [31:0] rdata;
    logic [15:0] pc;
    logic [15:0] ret;
    logic [7:0] sflags;
    logic [7:0] io;
    logic [31:0][7:0] gpr;
  } mcbx_core_t;
endpackage : mcbx_pkg
`default_nettype wire

/* File: design/mcbx_exec.sv */
// Execution unit for bit, multiply, compare, skip, jump and branch operations
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`include "mcbx_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module mcbx_exec (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Core state
  output logic o_busy,
  output logic [15:0] o_pc
);

  mcbx_pkg::mcbx_core_t cur;
  mcbx_pkg::mcbx_core_t next_cur;
  mcbx_pkg::mcbx_instr_t ins;
  logic busy, acc, start, taken, long_next, is_br, sgn_d, sgn_r, frac, cmp_cin;
  logic [4:0] dix;
  logic [7:0] opd, opr, imm8, bclr_res, cmp_rhs, cmp_res;
  logic [8:0] cmp_diff;
  logic signed [17:0] prod;
  logic [15:0] prod16, mres, zptr, pc_inc, pc_rel, pc_skip, npc;
  logic [2:0] cyc;

  // Skip and branch condition decode
  function automatic logic mcbx_cond(
    input mcbx_pkg::mcbx_op_t op,
    input logic [7:0] f,
    input logic [2:0] sel,
    input logic eq,
    input logic rb,
    input logic ib
  );
    case (op)
      mcbx_pkg::OP_CMP_SKIP: mcbx_cond = eq;
      mcbx_pkg::OP_SKIP_REG_CLR: mcbx_cond = ~rb;
      mcbx_pkg::OP_SKIP_REG_SET: mcbx_cond = rb;
      mcbx_pkg::OP_SKIP_IO_CLR: mcbx_cond = ~ib;
      mcbx_pkg::OP_SKIP_IO_SET: mcbx_cond = ib;
      mcbx_pkg::OP_BR_FLAG_SET: mcbx_cond = f[sel];
      mcbx_pkg::OP_BR_FLAG_CLR: mcbx_cond = ~f[sel];
      mcbx_pkg::OP_BR_C1: mcbx_cond = f[`MCBX_FLAG_C];
      mcbx_pkg::OP_BR_C0: mcbx_cond = ~f[`MCBX_FLAG_C];
      mcbx_pkg::OP_BR_ULT: mcbx_cond = f[`MCBX_FLAG_C];
      mcbx_pkg::OP_BR_UGE: mcbx_cond = ~f[`MCBX_FLAG_C];
      mcbx_pkg::OP_BR_SGE: mcbx_cond = ~(f[`MCBX_FLAG_N] ^ f[`MCBX_FLAG_V]);
      mcbx_pkg::OP_BR_SLT: mcbx_cond = f[`MCBX_FLAG_N] ^ f[`MCBX_FLAG_V];
      mcbx_pkg::OP_BR_H1: mcbx_cond = f[`MCBX_FLAG_H];
      mcbx_pkg::OP_BR_H0: mcbx_cond = ~f[`MCBX_FLAG_H];
      mcbx_pkg::OP_BR_T1: mcbx_cond = f[`MCBX_FLAG_T];
      mcbx_pkg::OP_BR_T0: mcbx_cond = ~f[`MCBX_FLAG_T];
      mcbx_pkg::OP_BR_V1: mcbx_cond = f[`MCBX_FLAG_V];
      mcbx_pkg::OP_BR_V0: mcbx_cond = ~f[`MCBX_FLAG_V];
      mcbx_pkg::OP_BR_EQ: mcbx_cond = f[`MCBX_FLAG_Z];
      mcbx_pkg::OP_BR_NE: mcbx_cond = ~f[`MCBX_FLAG_Z];
      mcbx_pkg::OP_BR_NEG: mcbx_cond = f[`MCBX_FLAG_N];
      mcbx_pkg::OP_BR_POS: mcbx_cond = ~f[`MCBX_FLAG_N];
      default: mcbx_cond = 1'b0;
    endcase
  endfunction : mcbx_cond

  assign ins = mcbx_pkg::mcbx_instr_t'(i_avs_writedata);
  assign busy = (cur.st == mcbx_pkg::MCBX_EXEC);
  // A write completes on the edge where waitrequest is seen low
  assign acc = ~cur.wreq & i_avs_write;
  assign start = acc & (i_avs_address == `MCBX_A_INSTR);
  assign dix = ins.d;
  assign opd = cur.gpr[ins.d];
  assign opr = cur.gpr[ins.r];
  assign imm8 = ins.imm[7:0];
  assign bclr_res = opd & ~imm8;
  assign zptr = {cur.gpr[`MCBX_ZHI], cur.gpr[`MCBX_ZLO]};
  assign long_next = ins.imm[`MCBX_F_LONG];
  assign pc_inc = cur.pc + 16'h0001;
  // Offset wraps in 16 bits, so two's complement needs no sign extension
  assign pc_rel = pc_inc + ins.imm;
  assign pc_skip = pc_inc + (long_next ? 16'h0002 : 16'h0001);
  assign is_br = (ins.op >= mcbx_pkg::OP_BR_FLAG_SET) && (ins.op <= mcbx_pkg::OP_BR_POS);
  assign taken = mcbx_cond(ins.op, cur.sflags, ins.r[`MCBX_F_SEL], opd == opr,
                           opr[ins.imm[`MCBX_F_BIT]], cur.io[ins.imm[`MCBX_F_BIT]]);

  // One 9x9 signed multiplier serves all six product forms
  assign sgn_d = ins.op inside {mcbx_pkg::OP_PROD_S, mcbx_pkg::OP_PROD_SU,
                                mcbx_pkg::OP_FRAC_S, mcbx_pkg::OP_FRAC_SU};
  assign sgn_r = ins.op inside {mcbx_pkg::OP_PROD_S, mcbx_pkg::OP_FRAC_S};
  assign frac = ins.op inside {mcbx_pkg::OP_FRAC_U, mcbx_pkg::OP_FRAC_S,
                               mcbx_pkg::OP_FRAC_SU};
  assign prod = $signed({sgn_d & opd[7], opd}) * $signed({sgn_r & opr[7], opr});
  assign prod16 = prod[15:0];
  assign mres = frac ? {prod16[14:0], 1'b0} : prod16;

  assign cmp_rhs = (ins.op == mcbx_pkg::OP_CMP_IMM) ? imm8 : opr;
  assign cmp_cin = (ins.op == mcbx_pkg::OP_CMP_CARRY) & cur.sflags[`MCBX_FLAG_C];
  assign cmp_diff = {1'b0, opd} - {1'b0, cmp_rhs} - {8'h00, cmp_cin};
  assign cmp_res = cmp_diff[7:0];

  always_comb
  begin
    next_cur = cur;
    next_cur.wreq = 1'b1;
    npc = pc_inc;
    cyc = `MCBX_CYC_ONE;
    if (busy)
    begin
      next_cur.cnt = cur.cnt - 3'h1;
      if (cur.cnt == 3'h1)
        next_cur.st = mcbx_pkg::MCBX_IDLE;
    end
    // Writes wait while an operation runs; reads are served at once
    if (cur.wreq & (i_avs_read | (i_avs_write & ~busy)))
    begin
      next_cur.wreq = 1'b0;
      case (i_avs_address)
        `MCBX_A_PC: next_cur.rdata = {16'h0000, cur.pc};
        `MCBX_A_FLAGS: next_cur.rdata = {24'h000000, cur.sflags};
        `MCBX_A_IO: next_cur.rdata = {24'h000000, cur.io};
        `MCBX_A_STAT: next_cur.rdata = {28'h0000000, cur.last_cyc, busy};
        `MCBX_A_RET: next_cur.rdata = {16'h0000, cur.ret};
        default:
        begin
          if (i_avs_address[`MCBX_A_GPR_BIT])
            next_cur.rdata = {24'h000000, cur.gpr[i_avs_address[6:2]]};
          else
            next_cur.rdata = 32'h00000000;
        end
      endcase
    end
    if (acc)
    begin
      if (i_avs_address[`MCBX_A_GPR_BIT])
        next_cur.gpr[i_avs_address[6:2]] = i_avs_writedata[7:0];
      case (i_avs_address)
        `MCBX_A_PC: next_cur.pc = i_avs_writedata[15:0];
        `MCBX_A_FLAGS: next_cur.sflags = i_avs_writedata[7:0];
        `MCBX_A_IO: next_cur.io = i_avs_writedata[7:0];
        default: ;
      endcase
    end
    if (start)
    begin
      case (ins.op)
        mcbx_pkg::OP_BIT_CLEAR:
        begin
          next_cur.gpr[ins.d] = bclr_res;
          next_cur.sflags[`MCBX_FLAG_Z] = (bclr_res == 8'h00);
          next_cur.sflags[`MCBX_FLAG_N] = bclr_res[7];
          next_cur.sflags[`MCBX_FLAG_V] = 1'b0;
        end
        mcbx_pkg::OP_PROBE:
        begin
          next_cur.sflags[`MCBX_FLAG_Z] = (opd == 8'h00);
          next_cur.sflags[`MCBX_FLAG_N] = opd[7];
          next_cur.sflags[`MCBX_FLAG_V] = 1'b0;
        end
        mcbx_pkg::OP_PROD_U, mcbx_pkg::OP_PROD_S, mcbx_pkg::OP_PROD_SU,
        mcbx_pkg::OP_FRAC_U, mcbx_pkg::OP_FRAC_S, mcbx_pkg::OP_FRAC_SU:
        begin
          next_cur.gpr[1] = mres[15:8];
          next_cur.gpr[0] = mres[7:0];
          // Carry is the product's top bit before the fractional shift
          next_cur.sflags[`MCBX_FLAG_C] = prod16[15];
          next_cur.sflags[`MCBX_FLAG_Z] = (mres == 16'h0000);
          cyc = `MCBX_CYC_TWO;
        end
        mcbx_pkg::OP_REL_JUMP:
        begin
          npc = pc_rel;
          cyc = `MCBX_CYC_TWO;
        end
        mcbx_pkg::OP_REL_INVOKE:
        begin
          npc = pc_rel;
          next_cur.ret = pc_inc;
          cyc = `MCBX_CYC_THREE;
        end
        mcbx_pkg::OP_IND_JUMP:
        begin
          npc = zptr;
          cyc = `MCBX_CYC_TWO;
        end
        mcbx_pkg::OP_IND_INVOKE:
        begin
          npc = zptr;
          next_cur.ret = pc_inc;
          cyc = `MCBX_CYC_THREE;
        end
        mcbx_pkg::OP_ABS_JUMP:
        begin
          npc = ins.imm;
          cyc = `MCBX_CYC_THREE;
        end
        mcbx_pkg::OP_ABS_INVOKE:
        begin
          npc = ins.imm;
          // Absolute form is two words long, so return lands two on
          next_cur.ret = pc_inc + 16'h0001;
          cyc = `MCBX_CYC_FOUR;
        end
        mcbx_pkg::OP_COMPARE, mcbx_pkg::OP_CMP_CARRY, mcbx_pkg::OP_CMP_IMM:
        begin
          next_cur.sflags[`MCBX_FLAG_C] = cmp_diff[8];
          next_cur.sflags[`MCBX_FLAG_N] = cmp_res[7];
          // Compare with carry only keeps zero set, so chained bytes test the whole word
          next_cur.sflags[`MCBX_FLAG_Z] = (cmp_res == 8'h00) &
            (cur.sflags[`MCBX_FLAG_Z] | (ins.op != mcbx_pkg::OP_CMP_CARRY));
          next_cur.sflags[`MCBX_FLAG_V] = (opd[7] & ~cmp_rhs[7] & ~cmp_res[7]) |
                                          (~opd[7] & cmp_rhs[7] & cmp_res[7]);
          next_cur.sflags[`MCBX_FLAG_H] = (~opd[3] & cmp_rhs[3]) |
                                          (cmp_rhs[3] & cmp_res[3]) |
                                          (cmp_res[3] & ~opd[3]);
        end
        mcbx_pkg::OP_CMP_SKIP, mcbx_pkg::OP_SKIP_REG_CLR, mcbx_pkg::OP_SKIP_REG_SET,
        mcbx_pkg::OP_SKIP_IO_CLR, mcbx_pkg::OP_SKIP_IO_SET:
        begin
          if (taken)
          begin
            npc = pc_skip;
            cyc = long_next ? `MCBX_CYC_THREE : `MCBX_CYC_TWO;
          end
        end
        default:
        begin
          if (is_br & taken)
          begin
            npc = pc_rel;
            cyc = `MCBX_CYC_TWO;
          end
        end
      endcase
      next_cur.pc = npc;
      next_cur.cnt = cyc;
      next_cur.last_cyc = cyc;
      next_cur.st = mcbx_pkg::MCBX_EXEC;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cur <= '0;
      cur.st <= mcbx_pkg::MCBX_IDLE;
      cur.wreq <= 1'b1;
      cur.pc <= `MCBX_RST_PC;
      cur.sflags <= `MCBX_RST_FLAGS;
    end
    else
      cur <= next_cur;
  end

  assign o_avs_readdata = cur.rdata;
  assign o_avs_waitrequest = cur.wreq;
  // One-hot code: this bit alone marks the running state
  assign o_busy = cur.st[1];
  assign o_pc = cur.pc;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  property p_bit_clear;
    start && ins.op == mcbx_pkg::OP_BIT_CLEAR |=>
      cur.gpr[$past(dix)] == $past(bclr_res) && !cur.sflags[`MCBX_FLAG_V] ##1 !busy;
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear wrong");

  property p_probe;
    start && ins.op == mcbx_pkg::OP_PROBE |=> cur.gpr == $past(cur.gpr) &&
      cur.sflags[`MCBX_FLAG_N] == cur.gpr[$past(dix)][7] ##1 !busy;
  endproperty
  a_probe: assert property (p_probe) else $error("probe wrong");

  property p_prod;
    start && ins.op inside {mcbx_pkg::OP_PROD_U, mcbx_pkg::OP_PROD_S,
      mcbx_pkg::OP_PROD_SU} |=> {cur.gpr[1], cur.gpr[0]} == $past(prod16) && busy
      ##1 busy ##1 !busy;
  endproperty
  a_prod: assert property (p_prod) else $error("product wrong");

  property p_frac;
    start && frac |=> {cur.gpr[1], cur.gpr[0]} == ($past(prod16) << 1) ##2 !busy;
  endproperty
  a_frac: assert property (p_frac) else $error("fraction product wrong");

  property p_rel_invoke;
    start && ins.op == mcbx_pkg::OP_REL_INVOKE |=>
      cur.pc == $past(pc_rel) && cur.ret == $past(pc_inc) ##0 busy[*3] ##1 !busy;
  endproperty
  a_rel_invoke: assert property (p_rel_invoke) else $error("relative invoke wrong");

  property p_ind_jump;
    start && ins.op == mcbx_pkg::OP_IND_JUMP |=> cur.pc == $past(zptr) && busy
      ##1 busy ##1 !busy;
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong");

  property p_abs_invoke;
    start && ins.op == mcbx_pkg::OP_ABS_INVOKE |=>
      cur.ret == $past(pc_inc) + 16'h0001 ##0 busy[*4] ##1 !busy;
  endproperty
  a_abs_invoke: assert property (p_abs_invoke) else $error("absolute invoke wrong");

  property p_skip;
    start && ins.op == mcbx_pkg::OP_CMP_SKIP && opd == opr |=>
      cur.pc == $past(pc_skip) && cur.last_cyc == ($past(long_next) ? 3'h3 : 3'h2);
  endproperty
  a_skip: assert property (p_skip) else $error("compare skip wrong");

  property p_compare;
    start && ins.op inside {mcbx_pkg::OP_COMPARE, mcbx_pkg::OP_CMP_IMM} |=>
      cur.gpr == $past(cur.gpr) && cur.sflags[`MCBX_FLAG_C] == $past(opd < cmp_rhs)
      ##1 !busy;
  endproperty
  a_compare: assert property (p_compare) else $error("compare wrong");

  property p_not_taken;
    start && is_br && !taken |=> cur.pc == $past(pc_inc) ##1 !busy;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("branch not taken wrong");

  property p_signed_ge;
    start && ins.op == mcbx_pkg::OP_BR_SGE &&
      !(cur.sflags[`MCBX_FLAG_N] ^ cur.sflags[`MCBX_FLAG_V]) |=>
      cur.pc == $past(pc_rel) && busy ##1 busy ##1 !busy;
  endproperty
  a_signed_ge: assert property (p_signed_ge) else $error("signed branch wrong");

  c_prod: cover property (start && frac);
  c_abs_invoke: cover property (start && ins.op == mcbx_pkg::OP_ABS_INVOKE);
  c_long_skip: cover property (start && ins.op == mcbx_pkg::OP_CMP_SKIP && taken && long_next);
  c_br_taken: cover property (start && is_br && taken);

endmodule : mcbx_exec
`default_nettype wire

/* File: verification/test_cpu_multiply_compare_branch_exec.sv */
// Self-checking bench for the multiply, compare and branch execution block
`timescale 1ns/1ns
`default_nettype none
`include "mcbx_consts.svh"
module test_cpu_multiply_compare_branch_exec;
  logic i_clk = 1'h0;
  logic i_srst = 1'h1;
  logic [7:0] i_avs_address = 8'h00;
  logic i_avs_read = 1'h0;
  logic i_avs_write = 1'h0;
  logic [31:0] i_avs_writedata = 32'h00000000;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic o_busy;
  logic [15:0] o_pc;
  int err_count = 0;
  int comparisons = 0;
  logic [31:0] lfsr_q = 32'h000093C9;
  logic [31:0] rd_q;
  logic bsy_q;
  logic [7:0] m_r [32];
  logic [7:0] m_fl;
  logic [7:0] m_io;
  logic [15:0] m_pc;
  logic [15:0] m_ret;
  logic [2:0] m_cyc;

  mcbx_exec i_dut (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .o_busy(o_busy),
    .o_pc(o_pc)
  );

  always #10 i_clk = ~i_clk;

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd

  function automatic logic [7:0] ga(input logic [4:0] n);
    return {1'h1, n, 2'h0};
  endfunction : ga

  function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] d,
      input logic [4:0] r, input logic [15:0] imm);
    return {op, d, r, imm};
  endfunction : mk

  // Reference behaviour, applied to the bench's copy of the core state
  function automatic void model(input logic [31:0] ins);
    logic [5:0] op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] s;
    logic [8:0] df;
    logic [15:0] p;
    logic [15:0] nxt;
    logic [15:0] tgt;
    logic tk;
    op = ins[31:26];
    a = m_r[ins[25:21]];
    b = m_r[ins[20:16]];
    nxt = m_pc + 16'h0001;
    tgt = nxt + ins[15:0];
    m_pc = nxt;
    m_cyc = 3'h1;
    tk = 1'h0;
    p = 16'h0000;
    case (op)
      mcbx_pkg::OP_BIT_CLEAR, mcbx_pkg::OP_PROBE:
      begin
        s = (op == mcbx_pkg::OP_PROBE) ? a : a & ~ins[7:0];
        m_r[ins[25:21]] = s;
        m_fl[3:1] = {1'h0, s[7], s == 8'h00};
      end
      mcbx_pkg::OP_PROD_U, mcbx_pkg::OP_FRAC_U: p = a * b;
      mcbx_pkg::OP_PROD_S, mcbx_pkg::OP_FRAC_S: p = $signed(a) * $signed(b);
      mcbx_pkg::OP_PROD_SU, mcbx_pkg::OP_FRAC_SU: p = $signed(a) * $signed({1'h0, b});
      mcbx_pkg::OP_REL_JUMP, mcbx_pkg::OP_REL_INVOKE:
      begin
        m_pc = tgt;
        m_cyc = (op == mcbx_pkg::OP_REL_JUMP) ? 3'h2 : 3'h3;
      end
      mcbx_pkg::OP_IND_JUMP, mcbx_pkg::OP_IND_INVOKE:
      begin
        m_pc = {m_r[31], m_r[30]};
        m_cyc = (op == mcbx_pkg::OP_IND_JUMP) ? 3'h2 : 3'h3;
      end
      mcbx_pkg::OP_ABS_JUMP, mcbx_pkg::OP_ABS_INVOKE:
      begin
        m_pc = ins[15:0];
        m_cyc = (op == mcbx_pkg::OP_ABS_JUMP) ? 3'h3 : 3'h4;
      end
      mcbx_pkg::OP_COMPARE, mcbx_pkg::OP_CMP_CARRY, mcbx_pkg::OP_CMP_IMM:
      begin
        if (op == mcbx_pkg::OP_CMP_IMM)
          b = ins[7:0];
        df = {1'h0, a} - {1'h0, b} - ((op == mcbx_pkg::OP_CMP_CARRY) & m_fl[0]);
        s = df[7:0];
        m_fl[5] = (~a[3] & b[3]) | (b[3] & s[3]) | (s[3] & ~a[3]);
        m_fl[3] = (a[7] & ~b[7] & ~s[7]) | (~a[7] & b[7] & s[7]);
        m_fl[2] = s[7];
        m_fl[1] = (s == 8'h00) & ((op != mcbx_pkg::OP_CMP_CARRY) | m_fl[1]);
        m_fl[0] = df[8];
      end
      mcbx_pkg::OP_CMP_SKIP: tk = (a == b);
      mcbx_pkg::OP_SKIP_REG_CLR: tk = !b[ins[2:0]];
      mcbx_pkg::OP_SKIP_REG_SET: tk = b[ins[2:0]];
      mcbx_pkg::OP_SKIP_IO_CLR: tk = !m_io[ins[2:0]];
      mcbx_pkg::OP_SKIP_IO_SET: tk = m_io[ins[2:0]];
      mcbx_pkg::OP_BR_FLAG_SET: tk = m_fl[ins[18:16]];
      mcbx_pkg::OP_BR_FLAG_CLR: tk = !m_fl[ins[18:16]];
      mcbx_pkg::OP_BR_C1, mcbx_pkg::OP_BR_ULT: tk = m_fl[0];
      mcbx_pkg::OP_BR_C0, mcbx_pkg::OP_BR_UGE: tk = !m_fl[0];
      mcbx_pkg::OP_BR_SGE: tk = !(m_fl[2] ^ m_fl[3]);
      mcbx_pkg::OP_BR_SLT: tk = m_fl[2] ^ m_fl[3];
      mcbx_pkg::OP_BR_H1: tk = m_fl[5];
      mcbx_pkg::OP_BR_H0: tk = !m_fl[5];
      mcbx_pkg::OP_BR_T1: tk = m_fl[6];
      mcbx_pkg::OP_BR_T0: tk = !m_fl[6];
      mcbx_pkg::OP_BR_V1: tk = m_fl[3];
      mcbx_pkg::OP_BR_V0: tk = !m_fl[3];
      mcbx_pkg::OP_BR_EQ: tk = m_fl[1];
      mcbx_pkg::OP_BR_NE: tk = !m_fl[1];
      mcbx_pkg::OP_BR_NEG: tk = m_fl[2];
      mcbx_pkg::OP_BR_POS: tk = !m_fl[2];
      default: tk = 1'h0;
    endcase
    if (op >= mcbx_pkg::OP_PROD_U && op <= mcbx_pkg::OP_FRAC_SU)
    begin
      m_fl[0] = p[15];
      if (op >= mcbx_pkg::OP_FRAC_U)
        p = p << 1;
      m_fl[1] = (p == 16'h0000);
      m_r[0] = p[7:0];
      m_r[1] = p[15:8];
      m_cyc = 3'h2;
    end
    if (op == mcbx_pkg::OP_REL_INVOKE || op == mcbx_pkg::OP_IND_INVOKE)
      m_ret = nxt;
    if (op == mcbx_pkg::OP_ABS_INVOKE)
      m_ret = nxt + 16'h0001;
    if (tk && op >= mcbx_pkg::OP_BR_FLAG_SET)
    begin
      m_pc = tgt;
      m_cyc = 3'h2;
    end
    else if (tk)
    begin
      m_pc = nxt + (ins[8] ? 16'h0002 : 16'h0001);
      m_cyc = ins[8] ? 3'h3 : 3'h2;
    end
  endfunction : model

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One Avalon access; starts one edge after the caller so no signal is driven twice
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge i_clk);
    i_avs_address <= a;
    i_avs_writedata <= d;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    t = 0;
    do
    begin
      @(posedge i_clk);
      t++;
    end
    while (o_avs_waitrequest !== 1'h0 && t < 50);
    if (t >= 50)
      check("waitrequest", {31'h0, o_avs_waitrequest}, 32'h00000000);
    rd_q = o_avs_readdata;
    bsy_q = o_busy;
    i_avs_write <= 1'h0;
    i_avs_read <= 1'h0;
  endtask : bus

  task automatic wg(input logic [4:0] n, input logic [7:0] v);
    bus(1'h1, ga(n), {24'h000000, v});
    m_r[n] = v;
  endtask : wg

  task automatic chk(input logic [4:0] d);
    logic [4:0] g;
    // Port is looked at after a full access, never in the edge that may update it
    bus(1'h0, `MCBX_A_PC, 32'h00000000);
    check("pc port", {16'h0000, o_pc}, {16'h0000, m_pc});
    check("pc", rd_q, {16'h0000, m_pc});
    bus(1'h0, `MCBX_A_FLAGS, 32'h00000000);
    check("flags", rd_q & 32'h000000EF, {24'h000000, m_fl & 8'hEF});
    bus(1'h0, `MCBX_A_STAT, 32'h00000000);
    check("stat", rd_q, {28'h0000000, m_cyc, 1'h0});
    bus(1'h0, `MCBX_A_RET, 32'h00000000);
    check("ret", rd_q, {16'h0000, m_ret});
    for (int i = 0; i < 3; i++)
    begin
      g = (i == 2) ? d : 5'(i);
      bus(1'h0, ga(g), 32'h00000000);
      check("gpr", rd_q, {24'h000000, m_r[g]});
    end
  endtask : chk

  task automatic run(input logic [31:0] ins);
    int c;
    model(ins);
    bus(1'h1, `MCBX_A_INSTR, ins);
    c = 0;
    do
    begin
      @(posedge i_clk);
      c++;
    end
    while (o_busy === 1'h1 && c < 20);
    check("busy cycles", 32'(c - 1), {29'h0, m_cyc});
    chk(ins[25:21]);
  endtask : run

  // Pointer pair, I/O byte and start address are random on every trial
  task automatic trial(input logic [31:0] ins, input logic [7:0] va, input logic [7:0] vb,
      input logic [7:0] fl);
    logic [31:0] v;
    v = rnd();
    bus(1'h1, `MCBX_A_IO, {24'h000000, v[7:0]});
    m_io = v[7:0];
    bus(1'h1, `MCBX_A_PC, {16'h0000, v[31:16]});
    m_pc = v[31:16];
    wg(`MCBX_ZLO, v[15:8]);
    wg(`MCBX_ZHI, v[23:16]);
    wg(ins[25:21], va);
    wg(ins[20:16], vb);
    bus(1'h1, `MCBX_A_FLAGS, {24'h000000, fl});
    m_fl = fl;
    run(ins);
  endtask : trial

  task automatic end_of_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    #(20 * 40000);
    err_count++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] w;
    logic [31:0] v;
    logic [5:0] op;
    logic [4:0] r;
    repeat (8) @(posedge i_clk);
    i_srst <= 1'h0;
    for (int i = 0; i < 32; i++)
      m_r[i] = 8'h00;
    m_fl = 8'h00;
    m_io = 8'h00;
    m_pc = 16'h0000;
    m_ret = 16'h0000;
    m_cyc = 3'h0;
    chk(5'h1F);
    bus(1'h1, 8'h40, 32'hFFFFFFFF);
    bus(1'h0, 8'h40, 32'h00000000);
    check("unmapped", rd_q, 32'h00000000);
    bus(1'h0, `MCBX_A_INSTR, 32'h00000000);
    check("instr read", rd_q, 32'h00000000);
    trial(mk(mcbx_pkg::OP_PROD_S, 5'h02, 5'h03, 16'h0000), 8'h80, 8'h80, 8'h00);
    trial(mk(mcbx_pkg::OP_FRAC_S, 5'h02, 5'h03, 16'h0000), 8'h80, 8'h80, 8'h00);
    trial(mk(mcbx_pkg::OP_FRAC_U, 5'h04, 5'h05, 16'h0000), 8'hFF, 8'hFF, 8'h00);
    trial(mk(mcbx_pkg::OP_PROD_SU, 5'h00, 5'h01, 16'h0000), 8'hFF, 8'hFF, 8'h02);
    trial(mk(mcbx_pkg::OP_CMP_CARRY, 5'h06, 5'h07, 16'h0000), 8'h10, 8'h10, 8'h00);
    trial(mk(mcbx_pkg::OP_CMP_CARRY, 5'h06, 5'h07, 16'h0000), 8'h10, 8'h0F, 8'h03);
    trial(mk(mcbx_pkg::OP_REL_JUMP, 5'h00, 5'h00, 16'hFFFF), 8'h00, 8'h00, 8'h00);
    trial(mk(mcbx_pkg::OP_CMP_SKIP, 5'h08, 5'h09, 16'h0100), 8'h5A, 8'h5A, 8'h00);
    trial(mk(mcbx_pkg::OP_BR_SLT, 5'h00, 5'h00, 16'h8000), 8'h00, 8'h00, 8'h04);
    // Every op code first, then random mixes
    for (int i = 0; i < 360; i++)
    begin
      w = rnd();
      v = rnd();
      op = (i < 41) ? 6'(i) : 6'(w % 32'h00000029);
      r = w[20:16];
      if (op == mcbx_pkg::OP_SKIP_REG_CLR || op == mcbx_pkg::OP_SKIP_REG_SET)
        r = w[25:21];
      trial(mk(op, w[25:21], r, w[15:0]), v[7:0], v[16] ? v[7:0] : v[15:8], v[31:24]);
    end
    // A register write issued while a four-cycle op runs must wait, not vanish
    w = mk(mcbx_pkg::OP_ABS_INVOKE, 5'h00, 5'h00, 16'hBEEF);
    model(w);
    bus(1'h1, `MCBX_A_INSTR, w);
    bus(1'h1, `MCBX_A_PC, 32'h00001234);
    check("busy at grant", {31'h0, bsy_q}, 32'h00000000);
    m_pc = 16'h1234;
    chk(5'h00);
    end_of_test();
  end
endmodule : test_cpu_multiply_compare_branch_exec
`default_nettype wire
